// ### core/wras_pkg.sv
// Purpose: Shared constants and types of the working register address and stack block.
// Assumes: One 100 MHz clock, active-low asynchronous reset.
// Notes:   Register indexes are word indexes; byte address is four times the index.
//
// What this block does
// [RULE_01] Register pair: high byte at even address, low byte at next odd address.
// [RULE_02] Direct register operands reach everything except the set 2 area.
// [RULE_03] Reset loads first pointer to C0H-C7H and second to C8H-CFH.
// [RULE_04] Common area working operands hit the same bytes on any page.
// [RULE_05] Software reaches C0H-CFH only through working register operands.
// [RULE_06] Short operand top bit picks first (0) or second (1) pointer.
// [RULE_07] Address is pointer upper five bits joined to operand low three bits.
// [RULE_08] 8-bit operand with upper nibble 1100B is a working register reference.
// [RULE_09] 8-bit working form: bit 3 picks pointer, bits 2 to 0 low bits.
// [RULE_10] Call pushes program counter; return pops it back.
// [RULE_11] Interrupt pushes program counter and flags; interrupt return pops both.
// [RULE_12] Push decrements before writing; pop increments after reading.
// [RULE_13] Stack pointer always holds the address of the last pushed byte.
// [RULE_14] Stack pointer high byte sits at D8H, low byte at D9H.
// [RULE_15] Reset leaves the stack pointer undefined.
// [RULE_16] Low byte carry or borrow propagates into the high byte.
// [RULE_17] Software should start the low byte at FFH, not 00H.
// [RULE_18] User stacks anywhere, with incrementing and decrementing push and pop.
// [RULE_19] Both slice pointers are readable and writable registers at D6H and D7H.
// [RULE_20] Slice pointers never resolve a working reference into set 2.
// [RULE_21] Low three pointer bits are ignored when forming the address.

package wras_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] IDX_SLICE_FIRST  = 8'hd6;
  localparam logic [7:0] IDX_SLICE_SECOND = 8'hd7;
  localparam logic [7:0] IDX_SP_HIGH      = 8'hd8;
  localparam logic [7:0] IDX_SP_LOW       = 8'hd9;
  localparam logic [7:0] IDX_STATUS       = 8'hf0;
  localparam logic [7:0] RST_SLICE_FIRST  = 8'hc0;
  localparam logic [7:0] RST_SLICE_SECOND = 8'hc8;
  localparam int         STAT_BUSY        = 0;
  localparam int         STAT_WRAP        = 1;

  // ****************************************
  // Operand decode
  // ****************************************
  localparam logic [3:0] WORK_NIBBLE      = 4'hc;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    WRAS_OP_NONE   = 4'h0,
    WRAS_OP_CALL   = 4'h1,
    WRAS_OP_RET    = 4'h2,
    WRAS_OP_INTR   = 4'h3,
    WRAS_OP_INTERRUPT_RETURN   = 4'h4,
    WRAS_OP_PUSH   = 4'h5,
    WRAS_OP_POP    = 4'h6,
    WRAS_OP_USER_PUSH_INCREMENTING = 4'h7,
    WRAS_OP_USER_PUSH_DECREMENTING = 4'h8,
    WRAS_OP_USER_POP_INCREMENTING  = 4'h9,
    WRAS_OP_USER_POP_DECREMENTING  = 4'ha
  } wras_op_t;

  typedef enum logic [2:0] {
    WRAS_ST_IDLE   = 3'h0,
    WRAS_ST_PUSH   = 3'h1,
    WRAS_ST_POP_RD = 3'h2,
    WRAS_ST_POP_WT = 3'h3,
    WRAS_ST_POP_CP = 3'h4,
    WRAS_ST_DONE   = 3'h5
  } wras_state_t;

endpackage : wras_pkg

// ### core/wras_res_if.sv
// Purpose: Carries operand requests to the resolver and resolved addresses back from it.
// Assumes: Driven and sampled on the core clock.
// Notes:   Resolved address follows a request by one cycle.
`timescale 1ns/100ps
`default_nettype none

interface wras_res_if;
  logic       req;
  logic       short_form;
  logic       pair;
  logic       second;
  logic [7:0] operand;
  logic [7:0] slice_first;
  logic [7:0] slice_second;
  logic       valid;
  logic       working;
  logic [7:0] addr;

  modport core (output req, short_form, pair, second, operand, slice_first,
                slice_second, input valid, working, addr);
  modport res  (input req, short_form, pair, second, operand, slice_first,
                slice_second, output valid, working, addr);
endinterface : wras_res_if

`default_nettype wire

// ### core/wras_resolve.sv
// Purpose: Turns register operands into 8-bit register file addresses.
// Assumes: Slice pointers are held by the parent.
// Notes:   No page input exists, so the common area is the same on every page.
`timescale 1ns/100ps
`default_nettype none

module wras_resolve (
  input  wire logic clk,
  input  wire logic rst_n,
  wras_res_if.res   rif
);

  logic       working;
  logic [3:0] nib;
  logic [7:0] ptr;
  logic [7:0] base;

  // ****************************************
  // Operand decode
  // ****************************************
  assign working = rif.short_form || (rif.operand[7:4] == wras_pkg::WORK_NIBBLE); // [RULE_08]
  assign nib     = rif.operand[3:0];
  assign ptr     = nib[3] ? rif.slice_second : rif.slice_first; // [RULE_06] [RULE_09]
  // Working form never leaves the 8-bit set 1 and prime map.
  assign base    = working ? {ptr[7:3], nib[2:0]} : rif.operand; // [RULE_07] [RULE_21] [RULE_02] [RULE_20] [RULE_04]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rif.valid   <= 1'b0;
      rif.working <= 1'b0;
      rif.addr    <= 8'h00;
    end else begin
      rif.valid   <= rif.req;
      rif.working <= working;
      if (rif.pair) begin
        rif.addr <= {base[7:1], rif.second}; // [RULE_01]
      end else begin
        rif.addr <= base;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_work_second;
    @(posedge clk) disable iff (!rst_n)
      (rif.req && !rif.short_form && rif.operand[7:3] == 5'h19 && !rif.pair)
      |=> (rif.addr == {$past(rif.slice_second[7:3]), $past(rif.operand[2:0])});
  endproperty
  a_work_second: assert property (p_work_second) else $error("Bad 8-bit working address."); // [RULE_09]

  property p_short_first;
    @(posedge clk) disable iff (!rst_n)
      (rif.req && rif.short_form && !rif.operand[3] && !rif.pair)
      |=> (rif.working && rif.addr[7:3] == $past(rif.slice_first[7:3]));
  endproperty
  a_short_first: assert property (p_short_first) else $error("Bad 4-bit working address."); // [RULE_06]

  property p_pair_odd;
    @(posedge clk) disable iff (!rst_n)
      (rif.req && rif.pair) |=> (rif.addr[0] == $past(rif.second));
  endproperty
  a_pair_odd: assert property (p_pair_odd) else $error("Pair byte order wrong."); // [RULE_01]

endmodule : wras_resolve

`default_nettype wire

// ### core/wras_top.sv
// Purpose: Slice pointers, stack pointer and stack sequencer with a Wishbone slave.
// Assumes: Register file returns read data the cycle after rf_re is seen.
// Notes:   Stack pointer bytes have no reset value.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module wras_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        opnd_req,
  input  wire logic        opnd_short,
  input  wire logic        opnd_pair,
  input  wire logic        opnd_second,
  input  wire logic [7:0]  opnd_val,
  output logic             opnd_valid,
  output logic             opnd_working,
  output logic      [7:0]  opnd_addr,
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_code,
  output logic             op_ready,
  input  wire logic [15:0] op_pc,
  input  wire logic [7:0]  op_flags,
  input  wire logic [7:0]  op_data,
  input  wire logic [7:0]  op_user_ptr,
  output logic             op_done,
  output logic      [15:0] ret_pc,
  output logic      [7:0]  ret_flags,
  output logic      [7:0]  ret_data,
  output logic      [7:0]  ret_user_ptr,
  output logic      [7:0]  rf_addr,
  output logic             rf_we,
  output logic             rf_re,
  output logic      [7:0]  rf_wdata,
  input  wire logic [7:0]  rf_rdata
);

  wras_res_if rif ();

  wras_pkg::wras_state_t state;
  wras_pkg::wras_op_t    op;

  logic [7:0]  slice_first;
  logic [7:0]  slice_second;
  logic [15:0] sp;
  logic [15:0] wp;
  logic [15:0] wp_step;
  logic [1:0]  step;
  logic [1:0]  last_step;
  logic [15:0] lat_pc;
  logic [7:0]  lat_flags;
  logic [7:0]  lat_data;
  logic [23:0] popbuf;
  logic [7:0]  push_byte;
  logic        is_push;
  logic        is_sys;
  logic        dir_up;
  logic        wrap;
  logic        wb_req;
  logic        wb_wr;
  logic [7:0]  wb_idx;
  logic [7:0]  rd_word;
  logic        accept;

  // ****************************************
  // Operand resolver
  // ****************************************
  assign rif.req          = opnd_req;
  assign rif.short_form   = opnd_short;
  assign rif.pair         = opnd_pair;
  assign rif.second       = opnd_second;
  assign rif.operand      = opnd_val;
  assign rif.slice_first  = slice_first;
  assign rif.slice_second = slice_second;
  assign opnd_valid       = rif.valid;
  assign opnd_working     = rif.working;
  assign opnd_addr        = rif.addr;

  wras_resolve u_resolve (
    .clk   (clk),
    .rst_n (rst_n),
    .rif   (rif)
  );

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_idx = wb_adr_i[9:2];
  assign wb_wr  = wb_req && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  always_comb begin
    case (wb_idx)
      wras_pkg::IDX_SLICE_FIRST:  rd_word = slice_first; // [RULE_19]
      wras_pkg::IDX_SLICE_SECOND: rd_word = slice_second; // [RULE_19]
      wras_pkg::IDX_SP_HIGH:      rd_word = sp[15:8]; // [RULE_14]
      wras_pkg::IDX_SP_LOW:       rd_word = sp[7:0]; // [RULE_14]
      wras_pkg::IDX_STATUS:       rd_word = {6'h00, wrap, !op_ready};
      default:                    rd_word = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_word};
    end
  end

  // ****************************************
  // Slice pointers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slice_first  <= wras_pkg::RST_SLICE_FIRST; // [RULE_03]
      slice_second <= wras_pkg::RST_SLICE_SECOND; // [RULE_03]
    end else if (wb_wr && wb_idx == wras_pkg::IDX_SLICE_FIRST) begin
      slice_first  <= wb_dat_i[7:0]; // [RULE_19]
    end else if (wb_wr && wb_idx == wras_pkg::IDX_SLICE_SECOND) begin
      slice_second <= wb_dat_i[7:0]; // [RULE_19]
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  // No reset branch: the pointer stays undefined until software loads it.
  always_ff @(posedge clk) begin // [RULE_15]
    if (state == wras_pkg::WRAS_ST_DONE && is_sys) begin
      sp <= wp; // [RULE_13] [RULE_16]
    end else if (wb_wr && wb_idx == wras_pkg::IDX_SP_HIGH) begin
      sp[15:8] <= wb_dat_i[7:0]; // [RULE_14]
    end else if (wb_wr && wb_idx == wras_pkg::IDX_SP_LOW) begin
      sp[7:0] <= wb_dat_i[7:0]; // [RULE_14]
    end
  end

  // Sticky flag: carry or borrow reached the high byte; write one clears.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap <= 1'b0;
    end else if (state == wras_pkg::WRAS_ST_DONE && is_sys && wp[15:8] != sp[15:8]) begin
      wrap <= 1'b1;
    end else if (wb_wr && wb_idx == wras_pkg::IDX_STATUS && wb_dat_i[wras_pkg::STAT_WRAP]) begin
      wrap <= 1'b0;
    end
  end

  // ****************************************
  // Operation decode
  // ****************************************
  assign accept   = op_valid && op_ready;
  assign op_ready = (state == wras_pkg::WRAS_ST_IDLE);

  assign is_push = (op == wras_pkg::WRAS_OP_CALL)   || (op == wras_pkg::WRAS_OP_INTR) ||
                   (op == wras_pkg::WRAS_OP_PUSH)   || (op == wras_pkg::WRAS_OP_USER_PUSH_INCREMENTING) ||
                   (op == wras_pkg::WRAS_OP_USER_PUSH_DECREMENTING); // [RULE_18]
  assign is_sys  = (op == wras_pkg::WRAS_OP_CALL) || (op == wras_pkg::WRAS_OP_RET) ||
                   (op == wras_pkg::WRAS_OP_INTR) || (op == wras_pkg::WRAS_OP_INTERRUPT_RETURN) ||
                   (op == wras_pkg::WRAS_OP_PUSH) || (op == wras_pkg::WRAS_OP_POP);
  assign dir_up  = is_sys ? !is_push :
                   (op == wras_pkg::WRAS_OP_USER_PUSH_INCREMENTING) || (op == wras_pkg::WRAS_OP_USER_POP_INCREMENTING); // [RULE_18]
  assign wp_step = dir_up ? wp + 16'h0001 : wp - 16'h0001; // [RULE_16]

  always_comb begin
    case (op)
      wras_pkg::WRAS_OP_CALL: last_step = 2'h1; // [RULE_10]
      wras_pkg::WRAS_OP_RET:  last_step = 2'h1; // [RULE_10]
      wras_pkg::WRAS_OP_INTR: last_step = 2'h2; // [RULE_11]
      wras_pkg::WRAS_OP_INTERRUPT_RETURN: last_step = 2'h2; // [RULE_11]
      default:                last_step = 2'h0;
    endcase
  end

  // Low program counter byte goes first so the high byte lands lower.
  always_comb begin
    if (op == wras_pkg::WRAS_OP_CALL || op == wras_pkg::WRAS_OP_INTR) begin
      case (step)
        2'h0:    push_byte = lat_pc[7:0];
        2'h1:    push_byte = lat_pc[15:8];
        default: push_byte = lat_flags; // [RULE_11]
      endcase
    end else begin
      push_byte = lat_data;
    end
  end

  // ****************************************
  // Stack sequencer
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= wras_pkg::WRAS_ST_IDLE;
    end else begin
      case (state)
        wras_pkg::WRAS_ST_IDLE: begin
          if (accept) begin
            state <= (op_code == wras_pkg::WRAS_OP_CALL   ||
                      op_code == wras_pkg::WRAS_OP_INTR   ||
                      op_code == wras_pkg::WRAS_OP_PUSH   ||
                      op_code == wras_pkg::WRAS_OP_USER_PUSH_INCREMENTING ||
                      op_code == wras_pkg::WRAS_OP_USER_PUSH_DECREMENTING) ? wras_pkg::WRAS_ST_PUSH :
                     (op_code == wras_pkg::WRAS_OP_NONE ||
                      op_code > wras_pkg::WRAS_OP_USER_POP_DECREMENTING) ? wras_pkg::WRAS_ST_IDLE :
                     wras_pkg::WRAS_ST_POP_RD;
          end
        end
        wras_pkg::WRAS_ST_PUSH: begin
          if (step == last_step) begin
            state <= wras_pkg::WRAS_ST_DONE;
          end
        end
        wras_pkg::WRAS_ST_POP_RD: begin
          state <= wras_pkg::WRAS_ST_POP_WT;
        end
        wras_pkg::WRAS_ST_POP_WT: begin
          state <= wras_pkg::WRAS_ST_POP_CP;
        end
        wras_pkg::WRAS_ST_POP_CP: begin
          state <= (step == last_step) ? wras_pkg::WRAS_ST_DONE : wras_pkg::WRAS_ST_POP_RD;
        end
        wras_pkg::WRAS_ST_DONE: begin
          state <= wras_pkg::WRAS_ST_IDLE;
        end
        default: begin
          state <= wras_pkg::WRAS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op        <= wras_pkg::WRAS_OP_NONE;
      lat_pc    <= 16'h0000;
      lat_flags <= 8'h00;
      lat_data  <= 8'h00;
    end else if (accept) begin
      op        <= wras_pkg::wras_op_t'(op_code);
      lat_pc    <= op_pc;
      lat_flags <= op_flags;
      lat_data  <= op_data;
    end
  end

  // Working pointer starts from the system or the user pointer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp   <= 16'h0000;
      step <= 2'h0;
    end else if (accept) begin
      step <= 2'h0;
      if (op_code >= wras_pkg::WRAS_OP_USER_PUSH_INCREMENTING) begin
        wp <= {8'h00, op_user_ptr}; // [RULE_18]
      end else begin
        wp <= sp;
      end
    end else if (state == wras_pkg::WRAS_ST_PUSH) begin
      wp   <= wp_step; // [RULE_12]
      step <= step + 2'h1;
    end else if (state == wras_pkg::WRAS_ST_POP_CP) begin
      wp   <= wp_step; // [RULE_12]
      step <= step + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      popbuf <= 24'h00_0000;
    end else if (accept) begin
      popbuf <= 24'h00_0000;
    end else if (state == wras_pkg::WRAS_ST_POP_CP) begin
      popbuf <= {popbuf[15:0], rf_rdata}; // [RULE_10] [RULE_11]
    end
  end

  // ****************************************
  // Register file port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_we    <= 1'b0;
      rf_re    <= 1'b0;
      rf_addr  <= 8'h00;
      rf_wdata <= 8'h00;
    end else begin
      rf_we <= (state == wras_pkg::WRAS_ST_PUSH);
      rf_re <= (state == wras_pkg::WRAS_ST_POP_RD);
      if (state == wras_pkg::WRAS_ST_PUSH) begin
        rf_addr  <= wp_step[7:0]; // [RULE_12]
        rf_wdata <= push_byte;
      end else if (state == wras_pkg::WRAS_ST_POP_RD) begin
        rf_addr  <= wp[7:0]; // [RULE_12]
      end
    end
  end

  // ****************************************
  // Results
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done      <= 1'b0;
      ret_pc       <= 16'h0000;
      ret_flags    <= 8'h00;
      ret_data     <= 8'h00;
      ret_user_ptr <= 8'h00;
    end else begin
      op_done <= (state == wras_pkg::WRAS_ST_DONE);
      if (state == wras_pkg::WRAS_ST_DONE) begin
        ret_pc       <= popbuf[15:0];
        ret_flags    <= popbuf[23:16];
        ret_data     <= popbuf[7:0];
        ret_user_ptr <= wp[7:0];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_call_go;
    accept && op_code == wras_pkg::WRAS_OP_CALL;
  endsequence

  sequence s_intr_go;
    accept && op_code == wras_pkg::WRAS_OP_INTR;
  endsequence

  property p_call_two;
    @(posedge clk) disable iff (!rst_n)
      s_call_go |-> ##2 rf_we [*2] ##1 (!rf_we && op_done);
  endproperty
  a_call_two: assert property (p_call_two) else $error("Call did not push two bytes."); // [RULE_10]

  property p_intr_three;
    @(posedge clk) disable iff (!rst_n)
      s_intr_go |-> ##2 rf_we [*3] ##1 (!rf_we && op_done);
  endproperty
  a_intr_three: assert property (p_intr_three) else $error("Interrupt push count wrong."); // [RULE_11]

  property p_push_predec;
    @(posedge clk) disable iff (!rst_n)
      (state == wras_pkg::WRAS_ST_PUSH && !dir_up) |=> (rf_we && rf_addr == 8'($past(wp) - 16'h0001));
  endproperty
  a_push_predec: assert property (p_push_predec) else $error("Push not pre-decremented."); // [RULE_12]

  property p_pop_postinc;
    @(posedge clk) disable iff (!rst_n)
      (state == wras_pkg::WRAS_ST_POP_RD && dir_up) |=> rf_re && rf_addr == $past(wp[7:0])
        ##2 (wp == $past(wp, 3) + 16'h0001);
  endproperty
  a_pop_postinc: assert property (p_pop_postinc) else $error("Pop not post-incremented."); // [RULE_12]

  property p_sp_top;
    @(posedge clk) disable iff (!rst_n)
      (state == wras_pkg::WRAS_ST_DONE && is_sys && is_push) |=> (sp[7:0] == $past(rf_addr));
  endproperty
  a_sp_top: assert property (p_sp_top) else $error("Stack pointer not at top byte."); // [RULE_13]

  property p_rp_reset;
    @(posedge clk) $rose(rst_n) |-> (slice_first == 8'hc0 && slice_second == 8'hc8);
  endproperty
  a_rp_reset: assert property (p_rp_reset) else $error("Slice pointers not at reset values."); // [RULE_03]

  property p_wb_ack;
    @(posedge clk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Acknowledge held two cycles.");

endmodule : wras_top

`default_nettype wire

// ### testbench/wras_top_tb_top.sv
// Purpose: Self-checking bench for the register address and stack block.
// Assumes: Register file model answers one cycle after a read strobe.
// Notes:   Stack pointer is loaded by software before any stack operation.
`timescale 1ns/100ps
`default_nettype none

module wras_top_tb_top;
  // ****************************************
  // Stimulus, design and register file model
  // ****************************************
  logic        clk, rst_n, cyc, stb, we, oreq, oshort, opair, osec, op_valid;
  logic [31:0] adr, wdat, wb_dat_o;
  logic [7:0]  oval, op_flags, op_data, op_uptr, rf_rdata, rf_addr, rf_wdata;
  logic [7:0]  opnd_addr, ret_flags, ret_data, ret_uptr, rd;
  logic [15:0] op_pc, ret_pc;
  logic [3:0]  op_code;
  logic        wb_ack_o, opnd_valid, opnd_working, op_ready, op_done, rf_we, rf_re;
  logic [7:0]  mem [256];
  int          errors, checked;

  wras_top wras_top_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .opnd_req(oreq), .opnd_short(oshort), .opnd_pair(opair),
    .opnd_second(osec), .opnd_val(oval), .opnd_valid(opnd_valid),
    .opnd_working(opnd_working), .opnd_addr(opnd_addr), .op_valid(op_valid),
    .op_code(op_code), .op_ready(op_ready), .op_pc(op_pc), .op_flags(op_flags),
    .op_data(op_data), .op_user_ptr(op_uptr), .op_done(op_done), .ret_pc(ret_pc),
    .ret_flags(ret_flags), .ret_data(ret_data), .ret_user_ptr(ret_uptr),
    .rf_addr(rf_addr), .rf_we(rf_we), .rf_re(rf_re), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (rf_we === 1'b1) mem[rf_addr] <= rf_wdata;
    rf_rdata <= (rf_re === 1'b1) ? mem[rf_addr] : ~rf_rdata;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      report_and_stop();
    end
  endtask : guard

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    logic a;
    int   n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, idx, 2'h0};
    wdat <= {24'h0, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      a = wb_ack_o;
      rd = wb_dat_o[7:0];
      if (a === 1'b1) break;
    end
    guard(n, 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk({8'h0, rd}, {8'h0, exp});
  endtask : rdchk

  task automatic opchk(input logic s, p, sc, input logic [7:0] v, input logic ew,
                       input logic [7:0] ea);
    @(posedge clk);
    oreq <= 1'b1;
    oshort <= s;
    opair <= p;
    osec <= sc;
    oval <= v;
    @(posedge clk);
    oreq <= 1'b0;
    @(negedge clk);
    chk({7'h0, opnd_valid, 7'h0, opnd_working}, {8'h1, 7'h0, ew});
    chk({8'h0, opnd_addr}, {8'h0, ea});
  endtask : opchk

  task automatic sop(input wras_pkg::wras_op_t c, input logic [15:0] pc,
                     input logic [7:0] fl, dt, up);
    logic a;
    int   n;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_pc <= pc;
    op_flags <= fl;
    op_data <= dt;
    op_uptr <= up;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      a = op_ready;
      @(posedge clk);
      if (a === 1'b1) break;
    end
    guard(n, 20);
    op_valid <= 1'b0;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (op_done === 1'b1) break;
    end
    guard(n, 60);
  endtask : sop

  initial begin
    {clk, rst_n, cyc, stb, we, oreq, oshort, opair, osec, op_valid} = '0;
    {adr, wdat, oval, op_flags, op_data, op_uptr, op_pc, op_code, rf_rdata} = '0;
    errors = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'hd6, 8'hc0);
    rdchk(8'hd7, 8'hc8);
    rdchk(8'h10, 8'h00);
    opchk(1'b1, 1'b0, 1'b0, 8'h05, 1'b1, 8'hc5);
    opchk(1'b0, 1'b0, 1'b0, 8'hcd, 1'b1, 8'hcd);
    wb(1'b1, 8'hd6, 8'h77);
    wb(1'b1, 8'hd7, 8'had);
    rdchk(8'hd6, 8'h77);
    opchk(1'b1, 1'b0, 1'b0, 8'h06, 1'b1, 8'h76);
    opchk(1'b1, 1'b0, 1'b0, 8'h0e, 1'b1, 8'hae);
    opchk(1'b0, 1'b0, 1'b0, 8'hcb, 1'b1, 8'hab);
    opchk(1'b0, 1'b0, 1'b0, 8'h45, 1'b0, 8'h45);
    opchk(1'b0, 1'b1, 1'b1, 8'h44, 1'b0, 8'h45);
    opchk(1'b0, 1'b1, 1'b0, 8'h44, 1'b0, 8'h44);
    wb(1'b1, 8'hd8, 8'h12);
    wb(1'b1, 8'hd9, 8'h00);
    sop(wras_pkg::WRAS_OP_PUSH, 16'h0, 8'h0, 8'h3c, 8'h0);
    chk({8'h0, mem[8'hff]}, 16'h003c);
    rdchk(8'hd8, 8'h11);
    rdchk(8'hd9, 8'hff);
    rdchk(8'hf0, 8'h02);
    wb(1'b1, 8'hf0, 8'h02);
    rdchk(8'hf0, 8'h00);
    sop(wras_pkg::WRAS_OP_POP, 16'h0, 8'h0, 8'h0, 8'h0);
    chk({8'h0, ret_data}, 16'h003c);
    rdchk(8'hd8, 8'h12);
    wb(1'b1, 8'hd8, 8'h00);
    wb(1'b1, 8'hd9, 8'hff);
    sop(wras_pkg::WRAS_OP_CALL, 16'hbeef, 8'h0, 8'h0, 8'h0);
    chk({mem[8'hfd], mem[8'hfe]}, 16'hbeef);
    rdchk(8'hd9, 8'hfd);
    sop(wras_pkg::WRAS_OP_INTR, 16'h1234, 8'h5a, 8'h0, 8'h0);
    chk({mem[8'hfa], mem[8'hfb]}, 16'h5a12);
    sop(wras_pkg::WRAS_OP_INTERRUPT_RETURN, 16'h0, 8'h0, 8'h0, 8'h0);
    chk(ret_pc, 16'h1234);
    chk({8'h0, ret_flags}, 16'h005a);
    sop(wras_pkg::WRAS_OP_RET, 16'h0, 8'h0, 8'h0, 8'h0);
    chk(ret_pc, 16'hbeef);
    rdchk(8'hd9, 8'hff);
    sop(wras_pkg::WRAS_OP_USER_PUSH_DECREMENTING, 16'h0, 8'h0, 8'h5a, 8'h40);
    chk({mem[8'h3f], ret_uptr}, 16'h5a3f);
    sop(wras_pkg::WRAS_OP_USER_POP_INCREMENTING, 16'h0, 8'h0, 8'h0, 8'h3f);
    chk({ret_data, ret_uptr}, 16'h5a40);
    sop(wras_pkg::WRAS_OP_USER_PUSH_INCREMENTING, 16'h0, 8'h0, 8'ha5, 8'h50);
    chk({mem[8'h51], ret_uptr}, 16'ha551);
    sop(wras_pkg::WRAS_OP_USER_POP_DECREMENTING, 16'h0, 8'h0, 8'h0, 8'h51);
    chk({ret_data, ret_uptr}, 16'ha550);
    report_and_stop();
  end
endmodule : wras_top_tb_top

`default_nettype wire
